/* File: shared/ptmr_pkg.sv */
// Constants, field layout and carrier types of the periodic interrupt timer.
// Assumes an 8-bit register port with byte addresses as listed here.
package ptmr_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Widths.
    localparam int ADDR_W  = 8;
    localparam int DATA_W  = 8;
    localparam int CNT_W   = 16;
    localparam int SEL_W   = 3;
    localparam int PRESC_W = 6;

    ////////////////////////////////////////////////////////////////////////////
    // Register addresses.
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h4b;
    localparam logic [ADDR_W-1:0] OFS_CNT_HI = 8'h4c;
    localparam logic [ADDR_W-1:0] OFS_CNT_LO = 8'h4d;
    localparam logic [ADDR_W-1:0] OFS_MOD_HI = 8'h4e;
    localparam logic [ADDR_W-1:0] OFS_MOD_LO = 8'h4f;

    ////////////////////////////////////////////////////////////////////////////
    // Status/control field positions.
    localparam int BIT_FLAG = 7;
    localparam int BIT_IE   = 6;
    localparam int BIT_HALT = 5;
    localparam int BIT_CLR  = 4;
    localparam int SEL_LSB  = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values.
    localparam logic             RST_FLAG = 1'b0;
    localparam logic             RST_IE   = 1'b0;
    localparam logic             RST_HALT = 1'b1;
    localparam logic [SEL_W-1:0] RST_SEL  = 3'h0;
    localparam logic [CNT_W-1:0] RST_CNT  = 16'h0000;
    localparam logic [CNT_W-1:0] RST_MOD  = 16'hffff;
    localparam logic [DATA_W-1:0] RD_NONE = 8'h00;

    // Largest prescaler shift; select code 111 folds onto it.
    localparam logic [SEL_W-1:0] SEL_MAX_SHIFT = 3'h6;

    ////////////////////////////////////////////////////////////////////////////
    // Carrier types.
    typedef struct packed {
        logic             flag;
        logic             irq_en;
        logic             halt;
        logic [SEL_W-1:0] sel;
    } ptmr_ctrl_type;

    typedef struct packed {
        logic wait_mode;
        logic stop_mode;
        logic break_active;
        logic break_clear_enable;
    } ptmr_sys_type;

endpackage : ptmr_pkg

/* File: src/ptmr_prescaler.sv */
// Prescaler of the periodic interrupt timer: a one-cycle tick every 2^n clocks.
// Assumes run and clear come from logic on the same clock.
`timescale 1ns/100ps
module ptmr_prescaler #(
    parameter int PRESC_W = ptmr_pkg::PRESC_W
) (
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic                       clear,
    input  wire logic                       run,
    input  wire logic [ptmr_pkg::SEL_W-1:0] sel,
    output logic                            tick
);
    import ptmr_pkg::*;

    if (PRESC_W < 6 || PRESC_W > 7) begin : g_bad_width
        $error("ptmr_prescaler: PRESC_W must be 6 or 7");
    end

    logic [PRESC_W-1:0] div_q;
    logic [PRESC_W-1:0] div_d;
    logic [SEL_W-1:0]   shift;
    logic [PRESC_W-1:0] mask;

    // Code 111 repeats the divide by 64 of code 110.
    assign shift = (sel > SEL_MAX_SHIFT) ? SEL_MAX_SHIFT : sel;  // [RULE1]
    assign mask  = {PRESC_W{1'b1}} >> (SEL_W'(PRESC_W) - shift);  // [RULE1]
    assign tick  = run && !clear && ((div_q & mask) == mask);     // [RULE1]
    assign div_d = clear ? '0 : (run ? div_q + 1'b1 : div_q);     // [RULE9]

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= '0;
        end else begin
            div_q <= div_d;
        end
    end

endmodule : ptmr_prescaler

/* File: src/ptmr_timer.sv */
// Periodic interrupt timer: 16-bit modulo up-counter with overflow flag.
// Assumes a byte register port on REF_CLK and mode inputs from logic on the same clock.
//
// Behaviour
// [RULE1] Counter ticks at bus clock divided by 1..64; codes 110 and 111 both give 64.
// [RULE2] Overflow flag sets when the counter wraps to zero after matching modulo.
// [RULE3] After reaching modulo the counter restarts from zero on the next tick.
// [RULE4] Interrupt request is flag and enable; enable is zero after reset.
// [RULE5] Flag clears by status read with flag set, then writing zero to it.
// [RULE6] An overflow between that read and write cancels the clearing write.
// [RULE7] Writing one to the flag leaves it unchanged.
// [RULE8] Halt bit freezes the counter; it is set by reset.
// [RULE9] Writing the clear bit zeroes counter and prescaler; it reads zero.
// [RULE10] Halt and clear in one write leave the counter halted at zero.
// [RULE11] High count read latches the low byte until the low byte is read.
// [RULE12] Counter registers are zero after reset and after a clear.
// [RULE13] Writing modulo high suppresses flag and interrupt until modulo low is written.
// [RULE14] Both modulo bytes reset to all ones.
// [RULE15] Wait mode keeps counting, blocks register access, interrupt still raised.
// [RULE16] Stop mode freezes counting and keeps all state.
// [RULE17] Break holds the counter.
// [RULE18] In break, status bits clear only with break clearing enabled.
// [RULE19] A clear armed before break completes after break.
// [RULE20] Software reads the low byte before leaving break if high was read.
// [RULE21] Software clears the counter before writing new modulo values.
// [RULE22] Software leaves halt clear before wait if the interrupt must wake.
// [RULE23] Status layout: flag 7, enable 6, halt 5, clear 4, select 2..0.
`timescale 1ns/100ps
module ptmr_timer #(
    parameter int PRESC_W = ptmr_pkg::PRESC_W
) (
    input  wire logic                        REF_CLK,
    input  wire logic                        RSTN,
    input  wire logic [ptmr_pkg::ADDR_W-1:0] ADDR,
    input  wire logic [ptmr_pkg::DATA_W-1:0] WDATA,
    input  wire logic                        WR_STB,
    input  wire logic                        RD_STB,
    input  wire ptmr_pkg::ptmr_sys_type      SYS,
    output logic      [ptmr_pkg::DATA_W-1:0] RDATA,
    output logic                             IRQ_REQ
);
    import ptmr_pkg::*;

    if (CNT_W != 2 * DATA_W) begin : g_bad_cnt
        $error("ptmr_timer: counter must be two bytes wide");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Address decode.

    function automatic logic ptmr_hit(
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] ofs
    );
        ptmr_hit = (addr == ofs);
    endfunction : ptmr_hit

    logic access_ok;
    logic wr;
    logic rd;
    logic wr_status;
    logic rd_status;
    logic rd_cnt_hi;
    logic rd_cnt_lo;
    logic wr_mod_hi;
    logic wr_mod_lo;
    logic protect;

    // The core cannot reach the registers while it sleeps in wait mode.
    assign access_ok = !SYS.wait_mode;                          // [RULE15]
    assign wr        = WR_STB && access_ok;
    assign rd        = RD_STB && access_ok;
    assign wr_status = wr && ptmr_hit(ADDR, OFS_STATUS);
    assign rd_status = rd && ptmr_hit(ADDR, OFS_STATUS);
    assign rd_cnt_hi = rd && ptmr_hit(ADDR, OFS_CNT_HI);
    assign rd_cnt_lo = rd && ptmr_hit(ADDR, OFS_CNT_LO);
    assign wr_mod_hi = wr && ptmr_hit(ADDR, OFS_MOD_HI);
    assign wr_mod_lo = wr && ptmr_hit(ADDR, OFS_MOD_LO);

    // The flag and its arming are frozen in break unless break clearing is enabled.
    assign protect = SYS.break_active && !SYS.break_clear_enable;  // [RULE18]

    ////////////////////////////////////////////////////////////////////////////
    // State.

    ptmr_ctrl_type     ctrl_q;
    ptmr_ctrl_type     ctrl_d;
    logic              arm_q;
    logic              arm_d;
    logic [CNT_W-1:0]  cnt_q;
    logic [CNT_W-1:0]  cnt_d;
    logic [CNT_W-1:0]  mod_q;
    logic [CNT_W-1:0]  mod_d;
    logic              inhibit_q;
    logic              inhibit_d;
    logic [DATA_W-1:0] lo_buf_q;
    logic [DATA_W-1:0] lo_buf_d;
    logic              latched_q;
    logic              latched_d;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic              irq_q;
    logic              irq_d;

    ////////////////////////////////////////////////////////////////////////////
    // Prescaler and counter.

    logic clear_req;
    logic run;
    logic tick;
    logic at_mod;
    logic ovf_evt;
    logic flag_set;

    // The clear bit is a pulse only; it never lands in a flip-flop of its own.
    assign clear_req = wr_status && WDATA[BIT_CLR];              // [RULE9]

    // Wait mode is deliberately absent here: the timer keeps running then.
    assign run = !ctrl_q.halt                                    // [RULE8]
              && !SYS.stop_mode                                  // [RULE16]
              && !SYS.break_active;                              // [RULE17]

    ptmr_prescaler #(
        .PRESC_W (PRESC_W)
    ) u_prescaler (
        .clk   (REF_CLK),
        .rst_n (RSTN),
        .clear (clear_req),
        .run   (run),
        .sel   (ctrl_q.sel),
        .tick  (tick)
    );

    assign at_mod = (cnt_q == mod_q);

    // A clear outranks a tick, so halt plus clear rests at zero.
    assign cnt_d = clear_req ? RST_CNT                           // [RULE10]
                 : (tick ? (at_mod ? RST_CNT                     // [RULE3]
                                   : cnt_q + 1'b1)
                         : cnt_q);

    assign ovf_evt  = tick && at_mod && !clear_req;              // [RULE2]
    assign flag_set = ovf_evt && !inhibit_q;                     // [RULE13]

    ////////////////////////////////////////////////////////////////////////////
    // Overflow flag and its two-step clear.

    logic flag_clr;
    logic arm_take;

    // Writing one does nothing; writing zero clears only when armed.
    assign flag_clr = wr_status && !WDATA[BIT_FLAG]              // [RULE7]
                   && arm_q && !protect;                         // [RULE5]
    // A read in protected break does not arm; an earlier arm survives it.
    assign arm_take = rd_status && ctrl_q.flag && !protect;      // [RULE19]

    // A new overflow wins over a clear in the same cycle and disarms.
    assign arm_d = (flag_set || flag_clr) ? 1'b0                 // [RULE6]
                 : (arm_take ? 1'b1 : arm_q);

    always_comb begin
        ctrl_d      = ctrl_q;
        ctrl_d.flag = flag_set || (ctrl_q.flag && !flag_clr);    // [RULE6]
        if (wr_status) begin
            ctrl_d.irq_en = WDATA[BIT_IE];                       // [RULE23]
            ctrl_d.halt   = WDATA[BIT_HALT];                     // [RULE8]
            ctrl_d.sel    = WDATA[SEL_LSB +: SEL_W];             // [RULE1]
        end
    end

    // An interrupt wakes the core from wait; the halt bit must stay clear for that.
    assign irq_d = ctrl_q.flag && ctrl_q.irq_en && !inhibit_q;   // [RULE4]

    ////////////////////////////////////////////////////////////////////////////
    // Modulo registers.

    // The high byte goes straight in; a half-written value would otherwise
    // raise a bogus overflow, hence the inhibit until the low byte arrives.
    assign mod_d = wr_mod_hi ? {WDATA, mod_q[DATA_W-1:0]}
                 : (wr_mod_lo ? {mod_q[CNT_W-1:DATA_W], WDATA} : mod_q);
    assign inhibit_d = wr_mod_hi ? 1'b1                          // [RULE13]
                     : (wr_mod_lo ? 1'b0 : inhibit_q);

    ////////////////////////////////////////////////////////////////////////////
    // Coherent counter read.

    // Reads keep latching in break; the low byte stays latched until it is read or a clear.
    assign latched_d = clear_req ? 1'b0                          // [RULE12]
                     : (rd_cnt_lo ? 1'b0                         // [RULE11]
                                  : (rd_cnt_hi ? 1'b1 : latched_q));
    assign lo_buf_d  = clear_req ? RST_CNT[DATA_W-1:0]           // [RULE12]
                     : ((rd_cnt_hi && !latched_q) ? cnt_q[DATA_W-1:0]  // [RULE11]
                                                  : lo_buf_q);

    ////////////////////////////////////////////////////////////////////////////
    // Read data.

    logic [DATA_W-1:0] status_val;
    logic [DATA_W-1:0] cnt_lo_val;
    logic [DATA_W-1:0] rd_val;

    // Bits 4 and 3 read zero; the clear bit is write-only.
    assign status_val = {ctrl_q.flag, ctrl_q.irq_en, ctrl_q.halt,  // [RULE23]
                         1'b0, 1'b0, ctrl_q.sel};                  // [RULE9]
    assign cnt_lo_val = latched_q ? lo_buf_q : cnt_q[DATA_W-1:0];  // [RULE11]

    assign rd_val = ptmr_hit(ADDR, OFS_STATUS) ? status_val
                  : ptmr_hit(ADDR, OFS_CNT_HI) ? cnt_q[CNT_W-1:DATA_W]
                  : ptmr_hit(ADDR, OFS_CNT_LO) ? cnt_lo_val
                  : ptmr_hit(ADDR, OFS_MOD_HI) ? mod_q[CNT_W-1:DATA_W]
                  : ptmr_hit(ADDR, OFS_MOD_LO) ? mod_q[DATA_W-1:0]
                  : RD_NONE;

    // Data stand only in the cycle after the read strobe.
    assign rdata_d = rd ? rd_val : RD_NONE;

    ////////////////////////////////////////////////////////////////////////////
    // Flip-flops.

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            ctrl_q <= '{flag: RST_FLAG, irq_en: RST_IE,          // [RULE4]
                        halt: RST_HALT, sel: RST_SEL};           // [RULE8]
            arm_q  <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            arm_q  <= arm_d;
        end
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            cnt_q     <= RST_CNT;                                // [RULE12]
            lo_buf_q  <= RST_CNT[DATA_W-1:0];
            latched_q <= 1'b0;
        end else begin
            cnt_q     <= cnt_d;
            lo_buf_q  <= lo_buf_d;
            latched_q <= latched_d;
        end
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            mod_q     <= RST_MOD;                                // [RULE14]
            inhibit_q <= 1'b0;
        end else begin
            mod_q     <= mod_d;
            inhibit_q <= inhibit_d;
        end
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rdata_q <= RD_NONE;
            irq_q   <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            irq_q   <= irq_d;
        end
    end

    assign RDATA   = rdata_q;
    assign IRQ_REQ = irq_q;

endmodule : ptmr_timer

/* File: verification/ptmr_timer_assertions.sv */
// Checker for the periodic interrupt timer, watching only the top module's ports.
// Assumes one clock domain with an asynchronous active-low reset.
`timescale 1ns/100ps
module ptmr_timer_chk #(
    parameter int PRESC_W = ptmr_pkg::PRESC_W
) (
    input wire logic                        REF_CLK,
    input wire logic                        RSTN,
    input wire logic [ptmr_pkg::ADDR_W-1:0] ADDR,
    input wire logic [ptmr_pkg::DATA_W-1:0] WDATA,
    input wire logic                        WR_STB,
    input wire logic                        RD_STB,
    input wire ptmr_pkg::ptmr_sys_type      SYS,
    input wire logic [ptmr_pkg::DATA_W-1:0] RDATA,
    input wire logic                        IRQ_REQ
);
    import ptmr_pkg::*;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);
    wire rd_ok  = RD_STB && !SYS.wait_mode;
    wire rd_st  = rd_ok && (ADDR == OFS_STATUS);
    wire rd_hi  = rd_ok && (ADDR == OFS_CNT_HI);
    wire wr_st  = WR_STB && !SYS.wait_mode && (ADDR == OFS_STATUS);
    wire mapped = (ADDR >= OFS_STATUS) && (ADDR <= OFS_MOD_LO);
    wire frozen = SYS.stop_mode || SYS.break_active;
    ////////////////////////////////////////////////////////////////////////////
    sequence st_flag_seen;
        rd_st ##1 RDATA[BIT_FLAG];
    endsequence
    sequence st_write_back;
        wr_st ##1 rd_st;
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    a_rdata_idle: assert property (!$past(RD_STB) |-> RDATA == RD_NONE)
        else $error("read data outside answer cycle");
    a_wait_blocks: assert property ($past(RD_STB && SYS.wait_mode) |-> RDATA == RD_NONE)
        else $error("read answered in wait mode");
    a_unmapped_zero: assert property ($past(RD_STB && !mapped) |-> RDATA == RD_NONE)
        else $error("unmapped read not zero");
    a_status_gaps: assert property (rd_st |=> !RDATA[BIT_CLR] && !RDATA[3])
        else $error("status bits 4 or 3 read one");
    a_irq_needs_flag: assert property ($past(rd_st) && IRQ_REQ |-> RDATA[BIT_FLAG] && RDATA[BIT_IE])
        else $error("request without flag and enable");
    a_frozen_count: assert property ((rd_hi && frozen) ##1 rd_hi |=> RDATA == $past(RDATA))
        else $error("count moved while frozen");
    a_flag_sticky: assert property (st_flag_seen ##0 rd_st |=> RDATA[BIT_FLAG])
        else $error("flag cleared without write");
    a_flag_write_one: assert property (st_flag_seen ##0 (wr_st && WDATA[BIT_FLAG]) ##1 rd_st |=> RDATA[BIT_FLAG])
        else $error("writing one cleared flag");
    a_break_protect: assert property (st_flag_seen ##0 (wr_st && SYS.break_active && !SYS.break_clear_enable)
        ##1 rd_st |=> RDATA[BIT_FLAG])
        else $error("flag cleared in protected break");
    a_ctrl_readback: assert property (st_write_back |=> RDATA[6:5] == $past(WDATA[6:5], 2)
        && RDATA[2:0] == $past(WDATA[2:0], 2))
        else $error("control fields not read back");
endmodule : ptmr_timer_chk

bind ptmr_timer ptmr_timer_chk #(.PRESC_W(PRESC_W)) u_chk (.REF_CLK(REF_CLK), .RSTN(RSTN), .ADDR(ADDR),
    .WDATA(WDATA), .WR_STB(WR_STB), .RD_STB(RD_STB), .SYS(SYS), .RDATA(RDATA), .IRQ_REQ(IRQ_REQ));

/* File: verification/tb.sv */
// Self-checking bench for the periodic interrupt timer.
// Assumes the bench drives every register strobe and mode input itself.
`timescale 1ns/100ps
module tb;
    import ptmr_pkg::*;
    logic              ref_clk, rstn, wr_stb, rd_stb, pend, irq_req;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, exp_nxt, exp_q, msk_nxt, msk_q, got;
    ptmr_sys_type      sys;
    int                fails, compares;

    ptmr_timer u_dut (.REF_CLK(ref_clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR_STB(wr_stb),
        .RD_STB(rd_stb), .SYS(sys), .RDATA(rdata), .IRQ_REQ(irq_req));

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] seen, input logic [7:0] want);
        compares++;
        if (seen !== want) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : chk
    // Read data is judged one cycle after its strobe, where it stands.
    always @(posedge ref_clk) begin
        if (pend && msk_q !== 8'h00) chk(rdata & msk_q, exp_q);
        if (pend) got <= rdata;
        pend <= rd_stb;
        exp_q <= exp_nxt;
        msk_q <= msk_nxt;
    end
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        addr <= a;
        rd_stb <= 1'b1;
        wr_stb <= 1'b0;
        exp_nxt <= e;
        msk_nxt <= m;
        @(posedge ref_clk);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        rd_stb <= 1'b0;
        @(posedge ref_clk);
    endtask : wr
    task automatic idle(input int n);
        rd_stb <= 1'b0;
        wr_stb <= 1'b0;
        repeat (n) @(posedge ref_clk);
    endtask : idle
    // Two live low-byte reads gap cycles apart; the phase of the prescaler cancels out.
    task automatic diff(input int gap, input logic [7:0] d);
        logic [7:0] v;
        rd(OFS_CNT_LO, 8'h00, 8'h00);
        idle(3);
        v = got;
        idle(gap - 4);
        rd(OFS_CNT_LO, 8'h00, 8'h00);
        idle(3);
        chk(got - v, d);
    endtask : diff
    task automatic close_out;
        $display("TB: compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : close_out
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {rstn, rd_stb, wr_stb, pend, addr, wdata, exp_nxt, msk_nxt, got} = '0;
        sys = '0;
        repeat (8) @(posedge ref_clk);
        rstn <= 1'b1;
        rd(OFS_STATUS, 8'h20, 8'hff);
        rd(OFS_CNT_HI, 8'h00, 8'hff);
        rd(OFS_CNT_LO, 8'h00, 8'hff);
        rd(OFS_MOD_HI, 8'hff, 8'hff);
        rd(OFS_MOD_LO, 8'hff, 8'hff);
        rd(8'h50, 8'h00, 8'hff);
        wr(OFS_STATUS, 8'h10);
        rd(OFS_CNT_HI, 8'h00, 8'hff);
        idle(4);
        rd(OFS_CNT_HI, 8'h00, 8'hff);
        rd(OFS_CNT_LO, 8'h00, 8'hff);
        for (int s = 0; s < 8; s++) begin
            wr(OFS_STATUS, 8'h10 | s[7:0]);
            rd(OFS_CNT_LO, 8'h00, 8'hff);
            diff(8 << (s == 7 ? 6 : s), 8'h08);
        end
        wr(OFS_STATUS, 8'h30);
        rd(OFS_STATUS, 8'h20, 8'hff);
        diff(8, 8'h00);
        wr(OFS_MOD_HI, 8'h00);
        wr(OFS_STATUS, 8'h50);
        idle(300);
        rd(OFS_STATUS, 8'h00, 8'h80);
        chk({7'h00, irq_req}, 8'h00);
        wr(OFS_STATUS, 8'h70);
        wr(OFS_MOD_LO, 8'h02);
        wr(OFS_STATUS, 8'h50);
        idle(6);
        rd(OFS_STATUS, 8'hc0, 8'hff);
        rd(OFS_CNT_LO, 8'h00, 8'hfc);
        chk({7'h00, irq_req}, 8'h01);
        sys.stop_mode <= 1'b1;
        diff(8, 8'h00);
        rd(OFS_CNT_HI, 8'h00, 8'hff);
        rd(OFS_CNT_HI, 8'h00, 8'hff);
        // Unlatch the low byte here, or later live low-byte reads would see the stale buffer.
        rd(OFS_CNT_LO, 8'h02, 8'hff);
        sys.stop_mode <= 1'b0;
        rd(OFS_STATUS, 8'hc0, 8'hc0);
        idle(4);
        wr(OFS_STATUS, 8'h60);
        rd(OFS_STATUS, 8'he0, 8'hff);
        wr(OFS_STATUS, 8'he0);
        rd(OFS_STATUS, 8'he0, 8'hff);
        wr(OFS_STATUS, 8'h60);
        rd(OFS_STATUS, 8'h60, 8'hff);
        idle(2);
        chk({7'h00, irq_req}, 8'h00);
        wr(OFS_STATUS, 8'h40);
        idle(6);
        wr(OFS_STATUS, 8'h60);
        rd(OFS_STATUS, 8'he0, 8'hff);
        sys.break_active <= 1'b1;
        rd(OFS_STATUS, 8'he0, 8'hff);
        rd(OFS_STATUS, 8'he0, 8'hff);
        wr(OFS_STATUS, 8'h60);
        rd(OFS_STATUS, 8'he0, 8'hff);
        wr(OFS_STATUS, 8'h40);
        diff(8, 8'h00);
        rd(OFS_CNT_HI, 8'h00, 8'hff);
        rd(OFS_CNT_LO, 8'h00, 8'hff);
        wr(OFS_STATUS, 8'h60);
        sys.break_active <= 1'b0;
        wr(OFS_STATUS, 8'h60);
        rd(OFS_STATUS, 8'h60, 8'hff);
        wr(OFS_STATUS, 8'h40);
        sys.wait_mode <= 1'b1;
        idle(8);
        chk({7'h00, irq_req}, 8'h01);
        rd(OFS_STATUS, 8'h00, 8'hff);
        wr(OFS_STATUS, 8'h20);
        sys.wait_mode <= 1'b0;
        rd(OFS_STATUS, 8'h40, 8'h60);
        rd(OFS_MOD_HI, 8'h00, 8'hff);
        rd(OFS_MOD_LO, 8'h02, 8'hff);
        idle(3);
        close_out();
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        close_out();
    end
endmodule : tb
